/* rtl/lscs_lane_cnt.v */
// one lane's error counter: counts the source chosen by its select bit
// assumes error strobes are one-cycle pulses in the management clock domain
`timescale 1ns/1ps
`include "lscs_map.vh"
module lscs_lane_cnt (
  input  wire                     sys_clk_i,
  input  wire                     rst_n_i,
  input  wire                     disp_err_i,
  input  wire                     dec_err_i,
  input  wire                     sel_i,
  input  wire                     clr_i,
  output reg  [`LSCS_CNT_W-1:0]   count_o
);
  wire ev;
  reg  [`LSCS_CNT_W-1:0] next_count;

  assign ev = sel_i ? dec_err_i : disp_err_i;

  always @* begin
    next_count = count_o;
    if (clr_i) begin
      // an error in the read cycle starts the fresh count at one
      next_count = ev ? `LSCS_CNT_ONE : `LSCS_ZERO16;
    end else if (ev && count_o != `LSCS_CNT_MAX) begin
      next_count = count_o + `LSCS_CNT_ONE; // saturate rather than wrap
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= `LSCS_ZERO16;
    end else begin
      count_o <= next_count;
    end
  end
endmodule

/* rtl/lscs_map.vh */
// register map and field layout for the lane sync / compensation status bank
// included by the bank and its lane counter; definitions only
`ifndef LSCS_MAP_VH
`define LSCS_MAP_VH
`define LSCS_ADDR_W        5
`define LSCS_DATA_W        16
`define LSCS_LANES         4
`define LSCS_CNT_W         16
`define LSCS_ADDR_SYNC     5'h17
`define LSCS_ADDR_CTC      5'h18
`define LSCS_ADDR_ECTL     5'h19
`define LSCS_ADDR_CNT_A    5'h1a
`define LSCS_ADDR_CNT_B    5'h1b
`define LSCS_ADDR_CNT_C    5'h1c
`define LSCS_ADDR_CNT_D    5'h1d
`define LSCS_ALIGN_BIT     4
`define LSCS_PARALLEL_SYNC_PIN_BIT     4
`define LSCS_DROP_LSB      12
`define LSCS_INS_LSB       8
`define LSCS_OVF_LSB       4
`define LSCS_UNF_LSB       0
`define LSCS_SEL_RST       4'h0
`define LSCS_PARALLEL_SYNC_PIN_RST     1'b1
`define LSCS_ZERO16        16'h0000
`define LSCS_ZERO11        11'h000
`define LSCS_CNT_MAX       16'hffff
`define LSCS_CNT_ONE       16'h0001
`endif

/* rtl/lscs_regs.v */
// lane sync, clock compensation status and error counter control registers
// assumes a management access port already deframed, synchronous to sys_clk_i
`timescale 1ns/1ps
`include "lscs_map.vh"
// Contract
// - alignment flag bit 4 sets when all four lanes realign to K28.3.
// - per-lane receive FIFO collision bits 3..0 set on FIFO self reset.
// - all status bits hold until read and clear on that read.
// - bits 15:5 of sync status and counter control read zero.
// - idle-drop bits 15..12 set when a lane drops an idle column.
// - idle-insert bits 11..8 set when a lane inserts an idle column.
// - overflow bits 7..4 set when a lane's compensation FIFO overflows.
// - underflow bits 3..0 set when a lane's compensation FIFO underflows.
// - common receive clock when setting is 1 (default), else per-lane clocks.
// - effective common clock setting is register bit AND the pin.
// - counter select 0 picks disparity errors, 1 picks decode errors.
// - each lane count register returns selected count, clears on read.
module lscs_regs (
  input  wire                        sys_clk_i,
  input  wire                        nrst_i,
  input  wire [`LSCS_ADDR_W-1:0]     reg_addr_i,
  input  wire                        reg_rd_i,
  input  wire                        reg_wr_i,
  input  wire [`LSCS_DATA_W-1:0]     reg_wdata_i,
  output reg  [`LSCS_DATA_W-1:0]     reg_rdata_o,
  output reg                         reg_rvalid_o,
  input  wire                        align_done_i,
  input  wire [`LSCS_LANES-1:0]      rx_fifo_coll_i,
  input  wire [`LSCS_LANES-1:0]      idle_drop_i,
  input  wire [`LSCS_LANES-1:0]      idle_insert_i,
  input  wire [`LSCS_LANES-1:0]      ctc_overflow_i,
  input  wire [`LSCS_LANES-1:0]      ctc_underflow_i,
  input  wire [`LSCS_LANES-1:0]      disp_err_i,
  input  wire [`LSCS_LANES-1:0]      dec_err_i,
  input  wire                        parallel_sync_pin_i,
  output reg                         receive_common_clock_select_o
);
  reg                         rst_meta_n;
  reg                         rst_n;
  reg                         align_flag;
  reg  [`LSCS_LANES-1:0]      coll_flag;
  reg  [`LSCS_LANES-1:0]      drop_flag;
  reg  [`LSCS_LANES-1:0]      ins_flag;
  reg  [`LSCS_LANES-1:0]      ovf_flag;
  reg  [`LSCS_LANES-1:0]      unf_flag;
  reg                         parallel_sync_pin_ctl;
  reg  [`LSCS_LANES-1:0]      cnt_sel;
  reg  [`LSCS_DATA_W-1:0]     next_rdata;
  wire                        rd_sync;
  wire                        rd_ctc;
  wire                        wr_ectl;
  wire [`LSCS_LANES-1:0]      cnt_clr;
  wire [`LSCS_CNT_W-1:0]      lane_count [0:`LSCS_LANES-1];

  // release the asynchronous reset cleanly on the clock
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  assign rd_sync = reg_rd_i && (reg_addr_i == `LSCS_ADDR_SYNC);
  assign rd_ctc  = reg_rd_i && (reg_addr_i == `LSCS_ADDR_CTC);
  assign wr_ectl = reg_wr_i && (reg_addr_i == `LSCS_ADDR_ECTL);

  // sticky flags: read clears, but a same-cycle event wins
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      align_flag <= 1'b0;
      coll_flag  <= {`LSCS_LANES{1'b0}};
      drop_flag  <= {`LSCS_LANES{1'b0}};
      ins_flag   <= {`LSCS_LANES{1'b0}};
      ovf_flag   <= {`LSCS_LANES{1'b0}};
      unf_flag   <= {`LSCS_LANES{1'b0}};
    end else begin
      align_flag <= (align_flag & ~rd_sync) | align_done_i;
      coll_flag  <= (coll_flag & ~{`LSCS_LANES{rd_sync}}) | rx_fifo_coll_i;
      drop_flag  <= (drop_flag & ~{`LSCS_LANES{rd_ctc}}) | idle_drop_i;
      ins_flag   <= (ins_flag & ~{`LSCS_LANES{rd_ctc}}) | idle_insert_i;
      ovf_flag   <= (ovf_flag & ~{`LSCS_LANES{rd_ctc}}) | ctc_overflow_i;
      unf_flag   <= (unf_flag & ~{`LSCS_LANES{rd_ctc}}) | ctc_underflow_i;
    end
  end

  // writable control: only the five low bits exist
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      parallel_sync_pin_ctl <= `LSCS_PARALLEL_SYNC_PIN_RST;
      cnt_sel   <= `LSCS_SEL_RST;
    end else if (wr_ectl) begin
      parallel_sync_pin_ctl <= reg_wdata_i[`LSCS_PARALLEL_SYNC_PIN_BIT];
      cnt_sel   <= reg_wdata_i[`LSCS_LANES-1:0];
    end
  end

  // the pin can only force per-lane clocking, never override a 0 bit
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      receive_common_clock_select_o <= 1'b0;
    end else begin
      receive_common_clock_select_o <= parallel_sync_pin_ctl & parallel_sync_pin_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `LSCS_LANES; g = g + 1) begin : lane
      // lane offset held at address width so the sum cannot widen
      localparam [`LSCS_ADDR_W-1:0] LANE_OFS = g;
      wire [`LSCS_ADDR_W-1:0] cnt_addr;
      assign cnt_addr   = `LSCS_ADDR_CNT_A + LANE_OFS;
      assign cnt_clr[g] = reg_rd_i && (reg_addr_i == cnt_addr);
      lscs_lane_cnt u_cnt (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n),
        .disp_err_i (disp_err_i[g]),
        .dec_err_i  (dec_err_i[g]),
        .sel_i      (cnt_sel[g]),
        .clr_i      (cnt_clr[g]),
        .count_o    (lane_count[g])
      );
    end
  endgenerate

  always @* begin
    next_rdata = `LSCS_ZERO16;
    case (reg_addr_i)
      `LSCS_ADDR_SYNC: next_rdata = {`LSCS_ZERO11, align_flag, coll_flag};
      `LSCS_ADDR_CTC:  next_rdata = {drop_flag, ins_flag, ovf_flag, unf_flag};
      `LSCS_ADDR_ECTL: next_rdata = {`LSCS_ZERO11, parallel_sync_pin_ctl, cnt_sel};
      `LSCS_ADDR_CNT_A: next_rdata = lane_count[0];
      `LSCS_ADDR_CNT_B: next_rdata = lane_count[1];
      `LSCS_ADDR_CNT_C: next_rdata = lane_count[2];
      `LSCS_ADDR_CNT_D: next_rdata = lane_count[3];
      default:         next_rdata = `LSCS_ZERO16; // unmapped reads as zero
    endcase
  end

  // read data captured with the pre-clear value, shown one cycle later
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o  <= `LSCS_ZERO16;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end
endmodule

/* testbench/lane_sync_ctc_status_regs_test.sv */
// self-checking bench for the lane sync and compensation status bank
// assumes the host model task is entered on a falling edge
`timescale 1ns/1ps
module lane_sync_ctc_status_regs_test;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [20:0] evv = 21'h0;
  logic [3:0]  disp = 4'h0;
  logic [3:0]  dec = 4'h0;
  logic        pin = 1'b1;
  logic [4:0]  addr;
  logic        rd, wr, csel, rv;
  logic [15:0] wdata, rdata, q;
  int          fail_count = 0;
  int          n_compared = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  lscs_host i_lscs_host (.clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
    .wr_o(wr), .wdata_o(wdata));
  lscs_regs i_lscs_regs (.sys_clk_i, .nrst_i, .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .align_done_i(evv[20]),
    .rx_fifo_coll_i(evv[19:16]), .idle_drop_i(evv[15:12]), .idle_insert_i(evv[11:8]),
    .ctc_overflow_i(evv[7:4]), .ctc_underflow_i(evv[3:0]), .disp_err_i(disp),
    .dec_err_i(dec), .parallel_sync_pin_i(pin), .receive_common_clock_select_o(csel));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    i_lscs_host.acc(1'b0, a, 16'h0000, q);
    chk({15'h0, rv}, 16'h0001);
    chk(q, e);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    rdc(5'h19, 16'h0010);
    chk({15'h0, csel}, 16'h0001);
    for (int i = 0; i < 21; i++) begin
      evv = 21'h1 << i;
      @(negedge sys_clk_i);
      evv = 21'h0;
      rdc(i < 16 ? 5'h18 : 5'h17, 16'h1 << (i % 16));
      rdc(i < 16 ? 5'h18 : 5'h17, 16'h0000);
    end
    evv = 21'h08000;
    rdc(5'h18, 16'h0000);
    evv = 21'h0;
    rdc(5'h18, 16'h8000);
    i_lscs_host.acc(1'b1, 5'h17, 16'hffff, q);
    rdc(5'h17, 16'h0000);
    rdc(5'h05, 16'h0000);
    i_lscs_host.acc(1'b1, 5'h19, 16'hffef, q);
    rdc(5'h19, 16'h000f);
    chk({15'h0, csel}, 16'h0000);
    i_lscs_host.acc(1'b1, 5'h19, 16'h0010, q);
    pin = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk({15'h0, csel}, 16'h0000);
    pin = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk({15'h0, csel}, 16'h0001);
    // pass 0 counts disparity errors, pass 1 decode errors; counts differ on purpose
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 5; k++) begin
        disp = k < 3 ? 4'hf : 4'h0;
        dec = 4'hf;
        @(negedge sys_clk_i);
      end
      disp = 4'h0;
      dec = 4'h0;
      for (int l = 0; l < 4; l++)
        rdc(5'h1a + l[4:0], s ? 16'h0005 : 16'h0003);
      rdc(5'h1a, 16'h0000);
      i_lscs_host.acc(1'b1, 5'h19, 16'h001f, q);
    end
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    tally_and_finish;
  end
endmodule

/* testbench/lscs_host.sv */
// management host model: one-cycle read or write strobe per access
// assumes each access starts on a falling edge of clk_i
`timescale 1ns/1ps
module lscs_host (
  input  logic        clk_i,
  input  logic [15:0] rdata_i,
  output logic [4:0]  addr_o,
  output logic        rd_o,
  output logic        wr_o,
  output logic [15:0] wdata_o
);
  initial begin
    addr_o = 5'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // address and data scrambled after the strobe so stale values never help
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    addr_o = a;
    wdata_o = d;
    rd_o = !w;
    wr_o = w;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
    q = rdata_i;
  endtask
endmodule

/* testbench/lscs_monitor.sv */
// checker for the status bank: read-clear flags, reserved zeros, pin gating
// assumes one-cycle read strobes and read data one cycle later
`timescale 1ns/1ps
module lscs_monitor (
  input logic        sys_clk_i,
  input logic        nrst_i,
  input logic [4:0]  reg_addr_i,
  input logic        reg_rd_i,
  input logic [15:0] reg_rdata_o,
  input logic        align_done_i,
  input logic [3:0]  rx_fifo_coll_i,
  input logic [3:0]  idle_drop_i,
  input logic [3:0]  ctc_underflow_i,
  input logic        parallel_sync_pin_i,
  input logic        receive_common_clock_select_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire r17 = reg_rd_i && reg_addr_i == 5'h17;
  wire r18 = reg_rd_i && reg_addr_i == 5'h18;
  align_flag_a:
    assert property (align_done_i ##1 r17 |=> reg_rdata_o[4]) else $error("align lost");
  coll_flag_a:
    assert property (rx_fifo_coll_i[0] ##1 r17 |=> reg_rdata_o[0]) else $error("coll lost");
  drop_flag_a:
    assert property (idle_drop_i[3] ##1 r18 |=> reg_rdata_o[15]) else $error("drop lost");
  unf_flag_a:
    assert property (ctc_underflow_i[1] ##1 r18 |=> reg_rdata_o[1]) else $error("unf lost");
  read_clears_a:
    assert property (r18 && !(|idle_drop_i) ##1 r18 |=> reg_rdata_o[15:12] == 4'h0)
      else $error("flag not cleared");
  set_wins_a:
    assert property (r18 && idle_drop_i[3] ##1 r18 |=> reg_rdata_o[15]) else $error("event lost");
  sync_upper_zero_a:
    assert property (r17 |=> reg_rdata_o[15:5] == 11'h000) else $error("upper bits set");
  pin_gates_a:
    assert property (!parallel_sync_pin_i |=> !receive_common_clock_select_o)
      else $error("pin ignored");
  cover property (r18 ##1 r18);
  cover property (receive_common_clock_select_o);
  cover property (reg_rd_i && reg_addr_i == 5'h1d);
endmodule
bind lscs_regs lscs_monitor i_lscs_monitor (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .align_done_i, .rx_fifo_coll_i, .idle_drop_i, .ctc_underflow_i,
  .parallel_sync_pin_i, .receive_common_clock_select_o);
